//--- logic/dbc_core.sv
// background debug controller: command execution, breakpoint, cycle steal and pin pulses
`timescale 1ns/1ps

// What this block does
// - memory command to ordinary memory steals exactly one bus cycle
// - cpu suspended only that cycle, peripherals run
// - write-control sets enable, read-status returns register
// - status shows live cpu wait/stop state
// - access-failed set when wait/stop blocks access
// - data-valid tells if last access data good
// - status register reachable only through debug commands
// - 16-bit breakpoint register, accessible while running
// - two-byte part id readable by user, debugger
// - force-reset write only works from background mode
// - halted commands refused while user program runs
// - halted commands access cpu registers directly
// - single step runs one instruction, halts again
// - resume and tagged resume restart user program
// - indexed commands address memory from index pair
// - status variants return status with the transfer
// - byte commands work running or halted
// - halt request ignored when debug enable clear
// - wait/stop blocks most commands; halt still wakes
// - long host low answered by 128-tick low pulse
// - enabled breakpoint match halts the cpu
// - acknowledge pulse per executed command when enabled
// - clock select picks bus or dedicated debug clock
// - pin low at reset release enters background
module dbc_core #(
  parameter logic [15:0] PART_ID = dbc_pkg::PART_ID_DEFAULT // arbitrary value
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            cmd_valid_i,     // decoded command present
  input  wire dbc_pkg::dbc_req_t cmd_i,         // command, address, data
  output logic                 cmd_ready_o,     // command taken when high
  output logic                 rsp_valid_o,     // one-cycle answer strobe
  output dbc_pkg::dbc_rsp_t    rsp_o,           // answer data and status
  input  wire logic            dbg_pin_i,       // debug pin level
  output logic                 dbg_pin_o,       // driven level, always low
  output logic                 dbg_pin_oe_o,    // high while pulling the pin low
  input  wire logic            dbg_clk_tick_i,  // dedicated debug clock tick
  output logic                 comm_clk_sel_o,  // 1 = bus clock base
  input  wire logic            cpu_wait_stop_i, // cpu sits in wait or stop
  input  wire logic            cpu_fetch_i,     // cpu starts an instruction
  input  wire logic [15:0]     cpu_fetch_addr_i,
  input  wire logic            cpu_insn_done_i, // one instruction completed
  input  wire logic [15:0]     cpu_hx_i,        // index register pair
  output logic                 cpu_halt_o,      // cpu held in background
  output logic                 cpu_step_o,      // run one instruction
  output logic                 cpu_resume_o,    // leave background
  output logic                 cpu_tag_o,       // resume is a tagged one
  output logic                 cpu_reg_act_o,   // cpu register access strobe
  output dbc_pkg::dbc_reg_t    cpu_reg_sel_o,
  output logic                 cpu_reg_we_o,
  output logic [15:0]          cpu_reg_wdata_o,
  input  wire logic [15:0]     cpu_reg_rdata_i,
  output logic                 steal_o,         // suspends the cpu this cycle
  output logic [15:0]          bus_addr_o,
  output logic                 bus_we_o,
  output logic [7:0]           bus_wdata_o,
  input  wire logic [7:0]      bus_rdata_i,
  output logic [15:0]          part_id_o,       // user-visible part id
  output logic                 force_reset_o    // one-cycle chip reset request
);

  dbc_pkg::dbc_state_t st_ff;   // all state
  dbc_pkg::dbc_state_t nxt_st;  // next state

  // commands that need a halted cpu
  function automatic logic halted_only(input dbc_pkg::dbc_cmd_t c);
    halted_only = (c >= dbc_pkg::CMD_FETCH_CPU_REG);
  endfunction

  // memory commands that steal a cycle
  function automatic logic is_mem(input dbc_pkg::dbc_cmd_t c);
    is_mem = (c inside {dbc_pkg::CMD_FETCH_BYTE, dbc_pkg::CMD_STORE_BYTE,
                        dbc_pkg::CMD_FETCH_BYTE_STATUS, dbc_pkg::CMD_STORE_BYTE_STATUS,
                        dbc_pkg::CMD_FETCH_INDEXED, dbc_pkg::CMD_STORE_INDEXED,
                        dbc_pkg::CMD_FETCH_INDEXED_STATUS,
                        dbc_pkg::CMD_STORE_INDEXED_STATUS});
  endfunction

  // commands whose answer carries the status byte
  function automatic logic wants_status(input dbc_pkg::dbc_cmd_t c);
    wants_status = (c inside {dbc_pkg::CMD_READ_STATUS, dbc_pkg::CMD_FETCH_BYTE_STATUS,
                              dbc_pkg::CMD_STORE_BYTE_STATUS,
                              dbc_pkg::CMD_FETCH_INDEXED_STATUS,
                              dbc_pkg::CMD_STORE_INDEXED_STATUS});
  endfunction

  // assemble the status/control byte
  function automatic logic [7:0] status_byte(input dbc_pkg::dbc_state_t s,
                                             input logic wait_stop);
    status_byte = 8'h00;
    status_byte[dbc_pkg::ST_DEBUG_ENABLE]  = s.dbg_en;
    status_byte[dbc_pkg::ST_BG_ACTIVE]     = s.halted;
    status_byte[dbc_pkg::ST_BKPT_ENABLE]   = s.bkpt_en;
    status_byte[dbc_pkg::ST_CLK_SELECT]    = s.clk_sel;
    status_byte[dbc_pkg::ST_WAIT_STOP]     = wait_stop;
    status_byte[dbc_pkg::ST_ACCESS_FAILED] = s.acc_fail;
    status_byte[dbc_pkg::ST_DATA_VALID]    = s.data_valid;
  endfunction

  logic             tick;       // one tick of the selected link clock
  logic             reply;      // answer goes out next cycle
  logic             refuse;     // answer marks the command as not run
  logic             bkpt_hit;   // enabled breakpoint reached
  logic [15:0]      mem_addr;   // address of a memory command
  dbc_pkg::dbc_cmd_t ans_cmd;   // command being answered

  // handshake: one command at a time, after the boot strap is caught
  assign cmd_ready_o = st_ff.boot_done && (st_ff.seq == dbc_pkg::SEQ_IDLE) && !st_ff.rsp_valid;

  assign tick     = st_ff.clk_sel | dbg_clk_tick_i;
  assign bkpt_hit = cpu_fetch_i && !st_ff.halted && st_ff.bkpt_en && st_ff.dbg_en &&
                    (cpu_fetch_addr_i == st_ff.bkpt);
  assign mem_addr = (cmd_i.cmd >= dbc_pkg::CMD_FETCH_INDEXED) ? cpu_hx_i : cmd_i.addr;

  // next-state logic
  always_comb begin
    nxt_st           = st_ff;
    reply            = 1'b0;
    refuse           = 1'b0;
    ans_cmd          = st_ff.cur_cmd;
    nxt_st.rsp_valid = 1'b0;
    nxt_st.steal     = 1'b0;
    nxt_st.reg_act   = 1'b0;
    nxt_st.step      = 1'b0;
    nxt_st.resume    = 1'b0;
    nxt_st.tag       = 1'b0;
    nxt_st.force_rst = 1'b0;
    // first cycle after reset: catch the strap on the pin
    if (!st_ff.boot_done) begin
      nxt_st.boot_done = 1'b1;
      nxt_st.halted    = !dbg_pin_i;
    end
    unique case (st_ff.seq)
      dbc_pkg::SEQ_IDLE: begin
        if (cmd_valid_i && cmd_ready_o) begin
          ans_cmd          = cmd_i.cmd;
          nxt_st.cur_cmd   = cmd_i.cmd;
          nxt_st.rsp.data  = 16'h0000;
          reply            = 1'b1;
          if (cpu_wait_stop_i && !(cmd_i.cmd inside {dbc_pkg::CMD_READ_STATUS,
              dbc_pkg::CMD_WRITE_CONTROL, dbc_pkg::CMD_HALT_REQ})) begin
            refuse = 1'b1;
            if (is_mem(cmd_i.cmd)) begin
              nxt_st.acc_fail   = 1'b1;
              nxt_st.data_valid = 1'b0;
            end
          end else if (halted_only(cmd_i.cmd) && !st_ff.halted) begin
            refuse = 1'b1;
          end else if (is_mem(cmd_i.cmd)) begin
            // special debugger-side registers answer without a bus cycle
            if (!cmd_i.cmd[0] && mem_addr == dbc_pkg::PART_ID_HIGH_ADDR) begin
              nxt_st.rsp.data = {8'h00, PART_ID[15:8]};
            end else if (!cmd_i.cmd[0] && mem_addr == dbc_pkg::PART_ID_LOW_ADDR) begin
              nxt_st.rsp.data = {8'h00, PART_ID[7:0]};
            end else if (cmd_i.cmd[0] && mem_addr == dbc_pkg::FORCE_RESET_ADDR) begin
              if (st_ff.halted) begin
                nxt_st.force_rst = cmd_i.data[dbc_pkg::FORCE_RESET_BIT];
              end else begin
                refuse = 1'b1;
              end
            end else begin
              // ordinary memory: steal one cycle next edge
              nxt_st.steal     = 1'b1;
              nxt_st.bus_addr  = mem_addr;
              nxt_st.bus_we    = cmd_i.cmd[0];
              nxt_st.bus_wdata = cmd_i.data[7:0];
              nxt_st.seq       = dbc_pkg::SEQ_ACCESS;
              reply            = 1'b0;
            end
          end else begin
            unique case (cmd_i.cmd)
              dbc_pkg::CMD_READ_STATUS: begin
              end
              dbc_pkg::CMD_WRITE_CONTROL: begin
                nxt_st.dbg_en  = cmd_i.data[dbc_pkg::ST_DEBUG_ENABLE];
                nxt_st.bkpt_en = cmd_i.data[dbc_pkg::ST_BKPT_ENABLE];
                nxt_st.clk_sel = cmd_i.data[dbc_pkg::ST_CLK_SELECT];
              end
              dbc_pkg::CMD_HALT_REQ: begin
                if (st_ff.dbg_en) begin
                  nxt_st.halted = 1'b1;
                end else begin
                  refuse = 1'b1;
                end
              end
              dbc_pkg::CMD_ACK_ON: nxt_st.ack_en = 1'b1;
              dbc_pkg::CMD_ACK_OFF: nxt_st.ack_en = 1'b0;
              dbc_pkg::CMD_FETCH_LAST: nxt_st.rsp.data = {8'h00, st_ff.last_data};
              dbc_pkg::CMD_FETCH_BREAKPOINT: nxt_st.rsp.data = st_ff.bkpt;
              dbc_pkg::CMD_STORE_BREAKPOINT: nxt_st.bkpt = cmd_i.data;
              dbc_pkg::CMD_FETCH_CPU_REG, dbc_pkg::CMD_STORE_CPU_REG: begin
                nxt_st.reg_act   = 1'b1;
                nxt_st.reg_sel   = dbc_pkg::dbc_reg_t'(cmd_i.addr[2:0]);
                nxt_st.reg_we    = cmd_i.cmd[0];
                nxt_st.reg_wdata = cmd_i.data;
                nxt_st.seq       = dbc_pkg::SEQ_ACCESS;
                reply            = 1'b0;
              end
              dbc_pkg::CMD_RESUME, dbc_pkg::CMD_TAGGED_RESUME: begin
                nxt_st.halted = 1'b0;
                nxt_st.resume = 1'b1;
                nxt_st.tag    = cmd_i.cmd[0];
              end
              dbc_pkg::CMD_SINGLE_STEP: begin
                nxt_st.halted = 1'b0;
                nxt_st.step   = 1'b1;
                nxt_st.seq    = dbc_pkg::SEQ_STEP;
                reply         = 1'b0;
              end
              default: refuse = 1'b1; // unknown code
            endcase
          end
        end
      end
      dbc_pkg::SEQ_ACCESS: begin
        // finish the stolen cycle or the cpu register access
        reply      = 1'b1;
        nxt_st.seq = dbc_pkg::SEQ_IDLE;
        if (st_ff.steal) begin
          nxt_st.acc_fail   = 1'b0;
          nxt_st.data_valid = 1'b1;
          if (!st_ff.bus_we) begin
            nxt_st.rsp.data  = {8'h00, bus_rdata_i};
            nxt_st.last_data = bus_rdata_i;
          end
        end else if (!st_ff.reg_we) begin
          nxt_st.rsp.data = cpu_reg_rdata_i;
        end
      end
      dbc_pkg::SEQ_STEP: begin
        // one instruction done: back to background
        if (cpu_insn_done_i) begin
          nxt_st.halted = 1'b1;
          nxt_st.seq    = dbc_pkg::SEQ_IDLE;
          reply         = 1'b1;
        end
      end
      default: nxt_st.seq = dbc_pkg::SEQ_IDLE;
    endcase
    // breakpoint halts even while a command is being taken
    if (bkpt_hit) begin
      nxt_st.halted = 1'b1;
    end
    // answer with status where the command asks for it
    if (reply) begin
      nxt_st.rsp_valid   = 1'b1;
      nxt_st.rsp.refused = refuse;
      nxt_st.rsp.status  = wants_status(ans_cmd) ?
                           status_byte(nxt_st, cpu_wait_stop_i) : 8'h00;
    end
    // pin pulses: sync answer and acknowledge
    if (dbg_pin_i) begin
      nxt_st.pin_armed = 1'b1;
    end
    unique case (st_ff.pin)
      dbc_pkg::PIN_IDLE: begin
        nxt_st.pin_cnt = 8'h00;
        if (st_ff.pin_armed && !dbg_pin_i) begin
          nxt_st.pin = dbc_pkg::PIN_LOW;
        end else if (reply && !refuse && st_ff.ack_en) begin
          nxt_st.pin = dbc_pkg::PIN_ACK;
        end
      end
      dbc_pkg::PIN_LOW: begin
        // measure the host low time, saturating at the minimum
        if (dbg_pin_i) begin
          nxt_st.pin_cnt = 8'h00;
          nxt_st.pin     = (st_ff.pin_cnt >= dbc_pkg::SYNC_LOW_MIN_TICKS) ?
                           dbc_pkg::PIN_SYNC : dbc_pkg::PIN_IDLE;
        end else if (tick && st_ff.pin_cnt < dbc_pkg::SYNC_LOW_MIN_TICKS) begin
          nxt_st.pin_cnt = st_ff.pin_cnt + 8'h01;
        end
      end
      dbc_pkg::PIN_SYNC: begin
        if (tick) begin
          nxt_st.pin_cnt = st_ff.pin_cnt + 8'h01;
          if (st_ff.pin_cnt == dbc_pkg::SYNC_PULSE_TICKS - 8'h01) begin
            nxt_st.pin = dbc_pkg::PIN_IDLE;
          end
        end
      end
      dbc_pkg::PIN_ACK: begin
        if (tick) begin
          nxt_st.pin_cnt = st_ff.pin_cnt + 8'h01;
          if (st_ff.pin_cnt == dbc_pkg::ACK_PULSE_TICKS - 8'h01) begin
            nxt_st.pin = dbc_pkg::PIN_IDLE;
          end
        end
      end
    endcase
  end

  // state register; everything clears, acknowledge starts off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from state, apart from the constant pin level and part id
  assign rsp_valid_o     = st_ff.rsp_valid;
  assign rsp_o           = st_ff.rsp;
  assign dbg_pin_o       = 1'b0;
  assign dbg_pin_oe_o    = (st_ff.pin == dbc_pkg::PIN_SYNC) || (st_ff.pin == dbc_pkg::PIN_ACK);
  assign comm_clk_sel_o  = st_ff.clk_sel;
  assign cpu_halt_o      = st_ff.halted;
  assign cpu_step_o      = st_ff.step;
  assign cpu_resume_o    = st_ff.resume;
  assign cpu_tag_o       = st_ff.tag;
  assign cpu_reg_act_o   = st_ff.reg_act;
  assign cpu_reg_sel_o   = st_ff.reg_sel;
  assign cpu_reg_we_o    = st_ff.reg_we;
  assign cpu_reg_wdata_o = st_ff.reg_wdata;
  assign steal_o         = st_ff.steal;
  assign bus_addr_o      = st_ff.bus_addr;
  assign bus_we_o        = st_ff.bus_we;
  assign bus_wdata_o     = st_ff.bus_wdata;
  assign part_id_o       = PART_ID;
  assign force_reset_o   = st_ff.force_rst;

  // helper: length of the current sync pulse in cycles
  logic [8:0] sync_run_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_run_ff <= 9'h000;
    end else if (st_ff.pin == dbc_pkg::PIN_SYNC) begin
      sync_run_ff <= sync_run_ff + 9'h001;
    end else begin
      sync_run_ff <= 9'h000;
    end
  end

  logic taken; // a command is taken this cycle
  assign taken = cmd_valid_i && cmd_ready_o;

  a_steal_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    steal_o |=> !steal_o ##1 !steal_o)
    else $error("steal lasted more than one cycle");

  a_steal_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    steal_o |=> rsp_valid_o && !rsp_o.refused && rsp_o.status[dbc_pkg::ST_DATA_VALID] ==
      wants_status(st_ff.cur_cmd))
    else $error("stolen cycle not answered next cycle");

  a_halted_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    (taken && halted_only(cmd_i.cmd) && !cpu_halt_o && !cpu_wait_stop_i)
      |=> rsp_valid_o && rsp_o.refused && !steal_o && !cpu_reg_act_o)
    else $error("halted command ran in user mode");

  a_halt_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (taken && cmd_i.cmd == dbc_pkg::CMD_HALT_REQ && !st_ff.dbg_en && !cpu_halt_o)
      |=> !cpu_halt_o && rsp_o.refused)
    else $error("halt request acted while debug disabled");

  a_bkpt_halts: assert property (@(posedge clk_i) disable iff (rst_i)
    (bkpt_hit && st_ff.seq == dbc_pkg::SEQ_IDLE && !taken && st_ff.boot_done)
      |=> cpu_halt_o)
    else $error("breakpoint match did not halt");

  a_sync_length: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(dbg_pin_oe_o) && $past(st_ff.pin) == dbc_pkg::PIN_SYNC && st_ff.clk_sel)
      |-> sync_run_ff == 9'h080)
    else $error("sync pulse not 128 cycles");

  a_ack_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.pin == dbc_pkg::PIN_IDLE && !st_ff.ack_en) |=> st_ff.pin != dbc_pkg::PIN_ACK)
    else $error("acknowledge sent while disabled");

  a_step_return: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.seq == dbc_pkg::SEQ_STEP && cpu_insn_done_i) |=> cpu_halt_o && rsp_valid_o)
    else $error("single step did not return to background");

  a_force_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    force_reset_o |-> $past(cpu_halt_o, 1))
    else $error("force reset from user mode");

  a_resume_runs: assert property (@(posedge clk_i) disable iff (rst_i)
    (taken && cmd_i.cmd == dbc_pkg::CMD_RESUME && cpu_halt_o && !cpu_wait_stop_i)
      |=> cpu_resume_o && !cpu_halt_o)
    else $error("resume did not leave background");

  a_wait_fail: assert property (@(posedge clk_i) disable iff (rst_i)
    (taken && is_mem(cmd_i.cmd) && cpu_wait_stop_i)
      |=> rsp_o.refused && !steal_o && st_ff.acc_fail && !st_ff.data_valid)
    else $error("blocked access not flagged");

endmodule

//--- logic/dbc_pkg.sv
// shared constants, command codes, carriers and state types of the debug controller
package dbc_pkg;

  // link timing, counted in ticks of the selected communication clock
  localparam logic [7:0]  SYNC_LOW_MIN_TICKS  = 8'h80; // host low time that counts as a probe
  localparam logic [7:0]  SYNC_PULSE_TICKS    = 8'h80; // length of the answering low pulse
  localparam logic [7:0]  ACK_PULSE_TICKS     = 8'h10; // length of an acknowledge pulse
  localparam logic [15:0] CMD_MIN_COMM_CLOCKS = 16'h01F4; // least length of a memory command

  // status/control byte layout
  localparam int ST_DEBUG_ENABLE  = 7; // host writable
  localparam int ST_BG_ACTIVE     = 6; // cpu halted in background
  localparam int ST_BKPT_ENABLE   = 5; // host writable
  localparam int ST_CLK_SELECT    = 4; // host writable, 1 = bus clock
  localparam int ST_WAIT_STOP     = 3; // live wait/stop state of the cpu
  localparam int ST_ACCESS_FAILED = 2; // last memory command failed
  localparam int ST_DATA_VALID    = 1; // last memory data valid

  // debugger-side memory map of the special registers
  localparam logic [15:0] PART_ID_HIGH_ADDR    = 16'h1806;
  localparam logic [15:0] PART_ID_LOW_ADDR     = 16'h1807;
  localparam logic [15:0] FORCE_RESET_ADDR     = 16'h1800;
  localparam int          FORCE_RESET_BIT      = 0;
  localparam logic [15:0] PART_ID_DEFAULT      = 16'h0C35; // arbitrary value

  // debug commands, already decoded from the serial link; in memory and cpu register commands bit 0 marks a store
  typedef enum logic [4:0] {
    CMD_READ_STATUS          = 5'h00,
    CMD_WRITE_CONTROL        = 5'h01,
    CMD_HALT_REQ             = 5'h02,
    CMD_ACK_ON               = 5'h03,
    CMD_ACK_OFF              = 5'h04,
    CMD_FETCH_BYTE           = 5'h06,
    CMD_STORE_BYTE           = 5'h05,
    CMD_FETCH_BYTE_STATUS    = 5'h08,
    CMD_STORE_BYTE_STATUS    = 5'h07,
    CMD_FETCH_LAST           = 5'h09,
    CMD_FETCH_BREAKPOINT     = 5'h0A,
    CMD_STORE_BREAKPOINT     = 5'h0B,
    CMD_FETCH_CPU_REG        = 5'h10,
    CMD_STORE_CPU_REG        = 5'h11,
    CMD_FETCH_INDEXED        = 5'h12,
    CMD_STORE_INDEXED        = 5'h13,
    CMD_FETCH_INDEXED_STATUS = 5'h14,
    CMD_STORE_INDEXED_STATUS = 5'h15,
    CMD_RESUME               = 5'h16,
    CMD_TAGGED_RESUME        = 5'h17,
    CMD_SINGLE_STEP          = 5'h18
  } dbc_cmd_t;

  // cpu register selected by the low address bits of a register command
  typedef enum logic [2:0] {
    REG_ACC   = 3'h0,
    REG_CCR   = 3'h1,
    REG_INDEX = 3'h2,
    REG_STACK = 3'h3,
    REG_PC    = 3'h4
  } dbc_reg_t;

  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'h0,
    SEQ_ACCESS = 2'h1,
    SEQ_STEP   = 2'h2
  } dbc_seq_t;

  typedef enum logic [1:0] {
    PIN_IDLE = 2'h0,
    PIN_LOW  = 2'h1,
    PIN_SYNC = 2'h2,
    PIN_ACK  = 2'h3
  } dbc_pin_t;

  typedef struct packed {
    dbc_cmd_t    cmd;
    logic [15:0] addr;
    logic [15:0] data;
  } dbc_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic [7:0]  status;
    logic        refused;
  } dbc_rsp_t;

  typedef struct packed {
    dbc_seq_t    seq;
    dbc_pin_t    pin;
    logic [7:0]  pin_cnt;
    logic        pin_armed;
    logic        boot_done;
    logic        halted;
    logic        dbg_en;
    logic        bkpt_en;
    logic        clk_sel;
    logic        ack_en;
    logic        acc_fail;
    logic        data_valid;
    logic [15:0] bkpt;
    logic [7:0]  last_data;
    dbc_cmd_t    cur_cmd;
    logic        rsp_valid;
    dbc_rsp_t    rsp;
    logic        steal;
    logic [15:0] bus_addr;
    logic        bus_we;
    logic [7:0]  bus_wdata;
    logic        reg_act;
    dbc_reg_t    reg_sel;
    logic        reg_we;
    logic [15:0] reg_wdata;
    logic        step;
    logic        resume;
    logic        tag;
    logic        force_rst;
  } dbc_state_t;

endpackage

//--- test/dbc_cpu_model.sv
// cpu and memory stand-in for the debug controller
`timescale 1ns/1ps
module dbc_cpu_model (
  input  wire logic              clk_i,
  input  wire logic              steal_i,
  input  wire logic [15:0]       addr_i,
  input  wire logic              step_i,
  input  wire dbc_pkg::dbc_reg_t sel_i,
  output logic [7:0]             rdata_o,
  output logic [15:0]            reg_o,
  output logic                   done_o,
  output logic                   tick_o
);
  logic [1:0] div_ff = 2'h0; // debug clock divider
  // byte is an address pattern, inverted while no cycle is stolen
  assign rdata_o = steal_i ? addr_i[7:0] ^ 8'h5A : ~(addr_i[7:0] ^ 8'h5A);
  assign reg_o   = 16'h1000 | {13'h0000, sel_i}; // register value names itself
  assign tick_o  = div_ff == 2'h3;
  // one instruction retires the cycle after a step
  always_ff @(posedge clk_i) begin
    div_ff <= div_ff + 2'h1;
    done_o <= step_i;
  end
endmodule

//--- test/dbc_core_tb.sv
// command sequences with expected answers for the debug controller
`timescale 1ns/1ps
module dbc_core_tb;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cmd_valid_i = 1'b0;
  dbc_pkg::dbc_req_t cmd_i = '0;
  logic              cpu_wait_stop_i = 1'b0;
  logic              host_low = 1'b0;  // host pulls the debug pin low
  logic              cpu_fetch_i = 1'b0;
  logic [15:0]       cpu_fetch_addr_i = 16'hBEEF;
  logic              comm_clk_sel_o, cpu_resume_o, cpu_tag_o, force_reset_o;
  logic              cmd_ready_o, rsp_valid_o, dbg_pin_oe_o, cpu_halt_o, cpu_step_o;
  logic              steal_o, done, tick;
  dbc_pkg::dbc_rsp_t rsp_o;
  dbc_pkg::dbc_reg_t cpu_reg_sel_o;
  logic [15:0]       bus_addr_o, reg_rd, part_id_o;
  logic [7:0]        mem_rd;
  int                mismatches = 0;
  int                cmp_count = 0;
  dbc_core DUT (.clk_i, .rst_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .rsp_valid_o, .rsp_o,
    .dbg_pin_i(~(dbg_pin_oe_o | host_low)), .dbg_pin_o(), .dbg_pin_oe_o, .dbg_clk_tick_i(tick),
    .comm_clk_sel_o, .cpu_wait_stop_i, .cpu_fetch_i, .cpu_fetch_addr_i,
    .cpu_insn_done_i(done), .cpu_hx_i(16'h0040), .cpu_halt_o, .cpu_step_o,
    .cpu_resume_o, .cpu_tag_o, .cpu_reg_act_o(), .cpu_reg_sel_o, .cpu_reg_we_o(),
    .cpu_reg_wdata_o(), .cpu_reg_rdata_i(reg_rd), .steal_o, .bus_addr_o, .bus_we_o(),
    .bus_wdata_o(), .bus_rdata_i(mem_rd), .part_id_o, .force_reset_o);
  dbc_cpu_model CPU (.clk_i, .steal_i(steal_o), .addr_i(bus_addr_o), .step_i(cpu_step_o),
    .sel_i(cpu_reg_sel_o), .rdata_o(mem_rd), .reg_o(reg_rd), .done_o(done), .tick_o(tick));
  // 25 MHz clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one command: hold it until taken, then wait for the answer strobe
  task automatic cmd(input dbc_pkg::dbc_cmd_t c, input logic [15:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    cmd_i <= '{c, a, d};
    cmd_valid_i <= 1'b1;
    for (n = 0; n < 50 && cmd_ready_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 50) mismatches++;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    for (n = 0; n < 50 && rsp_valid_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 50) mismatches++;
  endtask
  task automatic rdd(input dbc_pkg::dbc_cmd_t c, input logic [15:0] a, input logic [15:0] e);
    cmd(c, a, 16'h0000);
    chk("data", e, rsp_o.data);
  endtask
  task automatic sts(input logic [7:0] e);
    cmd(dbc_pkg::CMD_READ_STATUS, 16'h0000, 16'h0000);
    chk("status", {8'h00, e}, {8'h00, rsp_o.status});
  endtask
  task automatic rfs(input dbc_pkg::dbc_cmd_t c, input logic e);
    cmd(c, 16'h0002, 16'h0000);
    chk("refused", {15'h0000, e}, {15'h0000, rsp_o.refused});
  endtask
  // cycles of the next low pulse the device drives on the pin
  task automatic pulse(input logic [15:0] e);
    int n;
    for (n = 0; n < 4 && dbg_pin_oe_o !== 1'b1; n++) @(negedge clk_i);
    for (n = 0; n < 600 && dbg_pin_oe_o === 1'b1; n++) @(negedge clk_i);
    chk("pulse length", e, n[15:0]);
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    sts(8'h00);
    pulse(16'h0000);
    rfs(dbc_pkg::CMD_HALT_REQ, 1'b1);
    rfs(dbc_pkg::CMD_FETCH_CPU_REG, 1'b1);
    cmd(dbc_pkg::CMD_WRITE_CONTROL, 16'h0000, 16'h0090);
    chk("clock select", 16'h0001, {15'h0000, comm_clk_sel_o});
    // host probe: pin low for more than 128 bus-clock ticks
    @(posedge clk_i);
    host_low <= 1'b1;
    repeat (130) @(posedge clk_i);
    host_low <= 1'b0;
    pulse(16'h0080);
    cmd(dbc_pkg::CMD_ACK_ON, 16'h0000, 16'h0000);
    rfs(dbc_pkg::CMD_HALT_REQ, 1'b0);
    pulse(16'h0010);
    chk("halt", 16'h0001, {15'h0000, cpu_halt_o});
    cmd(dbc_pkg::CMD_ACK_OFF, 16'h0000, 16'h0000);
    pulse(16'h0010);
    sts(8'hD0);
    pulse(16'h0000);
    rdd(dbc_pkg::CMD_FETCH_CPU_REG, 16'h0002, 16'h1002);
    rdd(dbc_pkg::CMD_FETCH_BYTE, 16'h1234, 16'h006E);
    sts(8'hD2);
    rdd(dbc_pkg::CMD_FETCH_INDEXED, 16'h0000, 16'h001A);
    rdd(dbc_pkg::CMD_FETCH_LAST, 16'h0000, 16'h001A);
    cmd(dbc_pkg::CMD_STORE_BREAKPOINT, 16'h0000, 16'hBEEF);
    rdd(dbc_pkg::CMD_FETCH_BREAKPOINT, 16'h0000, 16'hBEEF);
    rdd(dbc_pkg::CMD_FETCH_BYTE, 16'h1806, 16'h000C);
    chk("part id", 16'h0C35, part_id_o);
    cmd(dbc_pkg::CMD_STORE_BYTE, 16'h1800, 16'h0001);
    chk("force reset", 16'h0001, {15'h0000, force_reset_o});
    rfs(dbc_pkg::CMD_SINGLE_STEP, 1'b0);
    chk("halt", 16'h0001, {15'h0000, cpu_halt_o});
    cmd(dbc_pkg::CMD_RESUME, 16'h0000, 16'h0000);
    chk("resume", 16'h0001, {15'h0000, cpu_resume_o});
    rfs(dbc_pkg::CMD_FETCH_CPU_REG, 1'b1);
    chk("halt", 16'h0000, {15'h0000, cpu_halt_o});
    cmd(dbc_pkg::CMD_STORE_BYTE, 16'h1800, 16'h0001);
    chk("refused", 16'h0001, {15'h0000, rsp_o.refused});
    cmd(dbc_pkg::CMD_WRITE_CONTROL, 16'h0000, 16'h00B0);
    // one fetch at the breakpoint address while running
    @(posedge clk_i);
    cpu_fetch_i <= 1'b1;
    @(posedge clk_i);
    cpu_fetch_i <= 1'b0;
    @(negedge clk_i);
    chk("halt", 16'h0001, {15'h0000, cpu_halt_o});
    cmd(dbc_pkg::CMD_TAGGED_RESUME, 16'h0000, 16'h0000);
    chk("tag", 16'h0001, {15'h0000, cpu_tag_o});
    @(posedge clk_i);
    cpu_wait_stop_i <= 1'b1;
    rfs(dbc_pkg::CMD_FETCH_BYTE, 1'b1);
    sts(8'hBC);
    // second reset with the pin held low by the host
    @(posedge clk_i);
    rst_i <= 1'b1;
    host_low <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    host_low <= 1'b0;
    @(negedge clk_i);
    chk("halt", 16'h0001, {15'h0000, cpu_halt_o});
    sts(8'h48);
    give_verdict();
  end
  // hang guard
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule
